// [common/mcdp_regs.svh]
// mcdp_regs.svh: register offsets, field positions and fixed values of the microcore datapath.
// assumes: included by package and design files by its bare name; definitions only.
`ifndef MCDP_REGS_SVH
`define MCDP_REGS_SVH

// apb byte offsets
`define MCDP_OFS_INSTR  8'h00
`define MCDP_OFS_ARITH  8'h04
`define MCDP_OFS_FDIR   8'h08
`define MCDP_OFS_FLAGS  8'h0C
`define MCDP_OFS_RSEL   8'h10
`define MCDP_OFS_RDATA  8'h14
`define MCDP_OFS_CTRL   8'h18
`define MCDP_OFS_STAT   8'h1C
`define MCDP_OFS_PC     8'h20

// arith condition register bits
`define MCDP_AR_OP_DONE 0
`define MCDP_AR_TST     1
`define MCDP_AR_ERR     2
`define MCDP_AR_ZERO    3
`define MCDP_AR_BUSY    4
`define MCDP_AR_DIAG_LO 8

// instruction operand fields
`define MCDP_USE_BASE   15
`define MCDP_BIT_VAL    4
`define MCDP_SH_LEFT    3
`define MCDP_SH_SGN     2
`define MCDP_SH_PAIR    1
`define MCDP_SH_IMM     0

// internal register indices for copy, load, store and readback
`define MCDP_IDX_IMM    4'h8
`define MCDP_IDX_PHI    4'h9
`define MCDP_IDX_PLO    4'hA
`define MCDP_IDX_BASE   4'hB
`define MCDP_IDX_CNT    4'hC

// fixed values
`define MCDP_RST_STATE  '0
`define MCDP_BYTE_POS   8
`define MCDP_SH_ONE     5'h01
`define MCDP_SH_ZERO    5'h00
`define MCDP_PC_STEP    10'h001

`endif

// [common/mcdp_pkg.sv]
// mcdp_pkg: types of the microcore datapath: opcodes, instruction word, alu carrier, state.
// assumes: mcdp_regs.svh on the include path.
`include "mcdp_regs.svh"
package mcdp_pkg;

	typedef enum logic [5:0] {
		MCDP_OP_NOP           = 6'h00,
		MCDP_OP_REG_COPY      = 6'h01,
		MCDP_OP_LOAD          = 6'h02,
		MCDP_OP_STORE         = 6'h03,
		MCDP_OP_SEL_MODE      = 6'h04,
		MCDP_OP_SET_BASE      = 6'h05,
		MCDP_OP_IMM_HIGH_LOAD = 6'h06,
		MCDP_OP_IMM_LOW_LOAD  = 6'h07,
		MCDP_OP_ADD           = 6'h08,
		MCDP_OP_ADDI          = 6'h09,
		MCDP_OP_SUB           = 6'h0A,
		MCDP_OP_SUBI          = 6'h0B,
		MCDP_OP_MUL           = 6'h0C,
		MCDP_OP_MULI          = 6'h0D,
		MCDP_OP_AND           = 6'h0E,
		MCDP_OP_OR            = 6'h0F,
		MCDP_OP_XOR           = 6'h10,
		MCDP_OP_NOT           = 6'h11,
		MCDP_OP_TO_SIGNED     = 6'h12,
		MCDP_OP_TO_INT        = 6'h13,
		MCDP_OP_SWAP          = 6'h14,
		MCDP_OP_SHIFT         = 6'h15,
		MCDP_OP_BYTE_SHIFT    = 6'h16,
		MCDP_OP_RST_REGS      = 6'h17,
		MCDP_OP_SET_CTRL_BIT  = 6'h18,
		MCDP_OP_SET_STAT_BIT  = 6'h19,
		MCDP_OP_SET_FLAG      = 6'h1A,
		MCDP_OP_CNT_FROM_ALU  = 6'h1B,
		MCDP_OP_CNT_FROM_MEM  = 6'h1C,
		MCDP_OP_JUMP_REL      = 6'h1D,
		MCDP_OP_JUMP_FAR      = 6'h1E,
		MCDP_OP_LOAD_JREG     = 6'h1F,
		MCDP_OP_TEST_FLAG     = 6'h20,
		MCDP_OP_SET_DIAG      = 6'h21
	} mcdp_op_t;

	typedef struct packed {
		mcdp_op_t    op;
		logic [1:0]  core;
		logic [3:0]  dst;
		logic [3:0]  src;
		logic [15:0] imm;
	} mcdp_instr_t;

	typedef struct packed {
		mcdp_op_t    op;
		logic [15:0] a;
		logic [15:0] b;
	} mcdp_alu_in_t;

	typedef struct packed {
		logic [7:0][15:0] gpr;
		logic [15:0]      imm_val;
		logic [15:0]      prod_hi;
		logic [15:0]      prod_lo;
		logic [15:0]      counter;
		logic [5:0]       base;
		logic             idx_mode;
		logic [3:0][15:0] ctrl;
		logic [3:0][15:0] stat;
		logic [3:0][7:0]  diag;
		logic [15:0]      flags;
		logic [15:0]      flag_dir;
		logic [3:0]       drive;
		logic [9:0]       pc;
		logic [9:0]       jreg;
		logic [5:0]       rsel;
		logic             sh_busy;
		logic             sh_left;
		logic             sh_sgn;
		logic             sh_pair;
		logic [2:0]       sh_reg;
		logic [4:0]       sh_cnt;
		logic             op_done;
		logic             tst;
		logic             err;
		logic             zero;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} mcdp_state_t;

endpackage

// [src/mcdp_sync2.sv]
// mcdp_sync2: two-stage synchroniser for the sixteen flag input pins.
// assumes: pins are asynchronous to clk; only the second stage is read.
`timescale 1ns/1ns
`default_nettype none
`include "mcdp_regs.svh"
module mcdp_sync2
	import mcdp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [15:0] pin_in,
	output var  logic [15:0] pin_sync
);

	typedef struct packed {
		logic [15:0] meta;
		logic [15:0] sync;
	} mcdp_sync_t;

	mcdp_sync_t s_q;
	mcdp_sync_t s_d;

	// first stage feeds the second only
	always_comb
	begin
		s_d.meta = pin_in;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_q <= `MCDP_RST_STATE;
		else
			s_q <= s_d;
	end

	assign pin_sync = s_q.sync;

endmodule
`default_nettype wire

// [src/mcdp_alu.sv]
// mcdp_alu: single-cycle add, subtract, logic, sign conversion and byte exchange.
// assumes: caller selects a and b; result is combinational.
`timescale 1ns/1ns
`default_nettype none
module mcdp_alu
	import mcdp_pkg::*;
(
	input  wire mcdp_alu_in_t alu_in,
	output var  logic [15:0]  alu_res
);

	// sign-magnitude and two's complement conversions keep bit 15 as the sign
	always_comb
	begin
		case (alu_in.op)
			MCDP_OP_ADD, MCDP_OP_ADDI: alu_res = alu_in.a + alu_in.b;
			MCDP_OP_SUB, MCDP_OP_SUBI: alu_res = alu_in.a - alu_in.b;
			MCDP_OP_AND:               alu_res = alu_in.a & alu_in.b;
			MCDP_OP_OR:                alu_res = alu_in.a | alu_in.b;
			MCDP_OP_XOR:               alu_res = alu_in.a ^ alu_in.b;
			MCDP_OP_NOT:               alu_res = ~alu_in.a;
			MCDP_OP_TO_SIGNED:         alu_res = alu_in.a[15] ? 16'(-{1'b0, alu_in.a[14:0]}) : alu_in.a;
			MCDP_OP_TO_INT:            alu_res = alu_in.a[15] ? {1'b1, 15'(-alu_in.a[14:0])} : alu_in.a;
			MCDP_OP_SWAP:              alu_res = {alu_in.a[7:0], alu_in.a[15:8]};
			default:                   alu_res = alu_in.a;
		endcase
	end

endmodule
`default_nettype wire

// [src/mcdp_core.sv]
// mcdp_core: data-side instruction execution of one microcore datapath, issued over apb.
// assumes: apb master on clk; flag pins asynchronous; one instruction per apb write.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mcdp_regs.svh"
module mcdp_core
	import mcdp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [15:0] flag_pin_in,
	output var  logic [15:0] flag_pin_out,
	output var  logic [15:0] flag_pin_oe,
	output var  logic [3:0]  drive_out
);

	mcdp_state_t  s_q;
	mcdp_state_t  s_d;
	mcdp_instr_t  ins;
	mcdp_alu_in_t alu_in;
	logic [15:0]  alu_res;
	logic [15:0]  pin_sync;
	logic [15:0]  dmem [0:63];
	logic [15:0]  mem_rdata;
	logic [15:0]  mem_wdata;
	logic [5:0]   mem_addr;
	logic         mem_we;
	logic         idxd;
	logic         exec;
	logic         alu_op;
	logic [15:0]  arith;

	// read one internal register by index
	function automatic logic [15:0] reg_rd(input mcdp_state_t s, input logic [3:0] i);
		case (i)
			`MCDP_IDX_IMM:  reg_rd = s.imm_val;
			`MCDP_IDX_PHI:  reg_rd = s.prod_hi;
			`MCDP_IDX_PLO:  reg_rd = s.prod_lo;
			`MCDP_IDX_BASE: reg_rd = {10'h000, s.base};
			`MCDP_IDX_CNT:  reg_rd = s.counter;
			default:        reg_rd = i[3] ? 16'h0000 : s.gpr[i[2:0]];
		endcase
	endfunction

	// write one internal register by index
	function automatic mcdp_state_t reg_wr(input mcdp_state_t s, input logic [3:0] i, input logic [15:0] v);
		reg_wr = s;
		case (i)
			`MCDP_IDX_IMM:  reg_wr.imm_val = v;
			`MCDP_IDX_PHI:  reg_wr.prod_hi = v;
			`MCDP_IDX_PLO:  reg_wr.prod_lo = v;
			`MCDP_IDX_BASE: reg_wr.base = v[5:0];
			`MCDP_IDX_CNT:  reg_wr.counter = v;
			default:
				if (!i[3])
					reg_wr.gpr[i[2:0]] = v;
		endcase
	endfunction

	// signed shifts hold the top bit
	// one shift position; 16-bit operands sit in the low half
	function automatic logic [31:0] shift_step(input logic [31:0] v, input logic left,
		input logic sgn, input logic pair);
		logic [31:0] r;
		r = v;
		if (pair)
		begin
			if (left)
				r = sgn ? {v[31], v[29:0], 1'b0} : {v[30:0], 1'b0};
			else
				r = sgn ? {v[31], v[31], v[30:1]} : {1'b0, v[31:1]};
		end
		else
		begin
			if (left)
				r[15:0] = sgn ? {v[15], v[13:0], 1'b0} : {v[14:0], 1'b0};
			else
				r[15:0] = sgn ? {v[15], v[15], v[14:1]} : {1'b0, v[15:1]};
		end
		shift_step = r;
	endfunction

	mcdp_sync2 u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.pin_in   (flag_pin_in),
		.pin_sync (pin_sync)
	);
	mcdp_alu u_alu (
		.alu_in  (alu_in),
		.alu_res (alu_res)
	);

	// instruction decode from the write data of an accepted instruction write
	assign ins    = mcdp_instr_t'(pwdata);
	assign exec   = psel & penable & s_q.pready & pwrite & (paddr == `MCDP_OFS_INSTR);
	assign alu_op = (ins.op >= MCDP_OP_ADD) && (ins.op <= MCDP_OP_BYTE_SHIFT);
	assign alu_in.op = ins.op;
	assign alu_in.a  = s_q.gpr[ins.dst[2:0]];
	assign alu_in.b  = (ins.op == MCDP_OP_ADD || ins.op == MCDP_OP_SUB) ? s_q.gpr[ins.src[2:0]] : s_q.imm_val;

	assign idxd      = s_q.idx_mode & ins.imm[`MCDP_USE_BASE];
	assign mem_addr  = idxd ? 6'(s_q.base + ins.imm[5:0]) : ins.imm[5:0];
	assign mem_rdata = dmem[mem_addr];
	assign mem_wdata = reg_rd(s_q, ins.src);
	assign mem_we    = exec & ~(s_q.sh_busy & alu_op) & (ins.op == MCDP_OP_STORE);
	// condition register image for readback
	always_comb
	begin
		arith = 16'h0000;
		arith[`MCDP_AR_OP_DONE] = s_q.op_done;
		arith[`MCDP_AR_TST] = s_q.tst;
		arith[`MCDP_AR_ERR] = s_q.err;
		arith[`MCDP_AR_ZERO] = s_q.zero;
		arith[`MCDP_AR_BUSY] = s_q.sh_busy;
		arith[`MCDP_AR_DIAG_LO +: 8] = s_q.diag[s_q.rsel[5:4]];
	end

	// next state: flags, running shift, apb slave, instruction execution
	always_comb
	begin
		s_d = s_q;
		s_d.flags = (s_q.flags & s_q.flag_dir) | (pin_sync & ~s_q.flag_dir);
		if (s_q.sh_busy)
		begin
			if (s_q.sh_pair)
				{s_d.prod_hi, s_d.prod_lo} = shift_step({s_q.prod_hi, s_q.prod_lo}, s_q.sh_left, s_q.sh_sgn, 1'b1);
			else
				s_d.gpr[s_q.sh_reg] = 16'(shift_step({16'h0000, s_q.gpr[s_q.sh_reg]}, s_q.sh_left,
					s_q.sh_sgn, 1'b0));
			s_d.sh_cnt = s_q.sh_cnt - `MCDP_SH_ONE;
			if (s_q.sh_cnt == `MCDP_SH_ONE)
			begin
				s_d.sh_busy = 1'b0;
				s_d.op_done = 1'b1;
			end
		end
		// apb setup cycle latches read data and the answer
		s_d.pready = psel & ~penable;
		s_d.pslverr = 1'b0;
		s_d.prdata = 32'h0000_0000;
		if (psel & ~penable)
		begin
			case (paddr)
				`MCDP_OFS_INSTR: s_d.prdata = 32'h0000_0000;
				`MCDP_OFS_ARITH: s_d.prdata = {16'h0000, arith};
				`MCDP_OFS_FDIR:  s_d.prdata = {16'h0000, s_q.flag_dir};
				`MCDP_OFS_FLAGS: s_d.prdata = {16'h0000, s_q.flags};
				`MCDP_OFS_RSEL:  s_d.prdata = {26'h000_0000, s_q.rsel};
				`MCDP_OFS_RDATA: s_d.prdata = {16'h0000, reg_rd(s_q, s_q.rsel[3:0])};
				`MCDP_OFS_CTRL:  s_d.prdata = {16'h0000, s_q.ctrl[s_q.rsel[5:4]]};
				`MCDP_OFS_STAT:  s_d.prdata = {16'h0000, s_q.stat[s_q.rsel[5:4]]};
				`MCDP_OFS_PC:    s_d.prdata = {6'h00, s_q.jreg, 6'h00, s_q.pc};
				default:         s_d.pslverr = 1'b1;
			endcase
		end
		// apb access edge: configuration writes
		if (psel & penable & s_q.pready & pwrite)
		begin
			case (paddr)
				`MCDP_OFS_FDIR:  s_d.flag_dir = pwdata[15:0];
				`MCDP_OFS_RSEL:  s_d.rsel = pwdata[5:0];
				`MCDP_OFS_ARITH:
					if (pwdata[`MCDP_AR_ERR])
						s_d.err = 1'b0;
				default: ;
			endcase
		end
		if (exec)
		begin
			if (s_q.sh_busy && alu_op)
				s_d.err = 1'b1;
			else
			begin
				s_d.pc = s_q.pc + `MCDP_PC_STEP;
				case (ins.op)
					MCDP_OP_REG_COPY: s_d = reg_wr(s_d, ins.dst, reg_rd(s_q, ins.src));
					MCDP_OP_LOAD: s_d = reg_wr(s_d, ins.dst, mem_rdata);
					MCDP_OP_SEL_MODE: s_d.idx_mode = ins.imm[0];
					MCDP_OP_SET_BASE: s_d.base = ins.imm[5:0];
					MCDP_OP_IMM_HIGH_LOAD: s_d.imm_val[15:8] = ins.imm[7:0];
					MCDP_OP_IMM_LOW_LOAD:  s_d.imm_val[7:0] = ins.imm[7:0];
					MCDP_OP_MUL, MCDP_OP_MULI:
					begin
						{s_d.prod_hi, s_d.prod_lo} = alu_in.a * ((ins.op == MCDP_OP_MUL) ?
							s_q.gpr[ins.src[2:0]] : s_q.imm_val);
						s_d.op_done = 1'b1;
					end
					MCDP_OP_ADD, MCDP_OP_ADDI, MCDP_OP_SUB, MCDP_OP_SUBI, MCDP_OP_AND, MCDP_OP_OR,
					MCDP_OP_XOR, MCDP_OP_NOT, MCDP_OP_TO_SIGNED, MCDP_OP_TO_INT, MCDP_OP_SWAP:
					begin
						s_d.gpr[ins.dst[2:0]] = alu_res;
						s_d.zero = (alu_res == 16'h0000);
						s_d.op_done = 1'b1;
					end
					MCDP_OP_SHIFT:
					begin
						s_d.sh_cnt = ins.src[`MCDP_SH_IMM] ? ins.imm[4:0] : s_q.gpr[ins.imm[2:0]][4:0];
						s_d.sh_left = ins.src[`MCDP_SH_LEFT];
						s_d.sh_sgn = ins.src[`MCDP_SH_SGN];
						s_d.sh_pair = ins.src[`MCDP_SH_PAIR];
						s_d.sh_reg = ins.dst[2:0];
						s_d.sh_busy = (s_d.sh_cnt != `MCDP_SH_ZERO);
						s_d.op_done = (s_d.sh_cnt == `MCDP_SH_ZERO);
					end
					MCDP_OP_BYTE_SHIFT:
					begin
						s_d.gpr[ins.dst[2:0]] = ins.src[`MCDP_SH_LEFT] ? (alu_in.a << `MCDP_BYTE_POS) :
							(alu_in.a >> `MCDP_BYTE_POS);
						s_d.op_done = 1'b1;
					end
					MCDP_OP_RST_REGS:
					begin
						s_d.ctrl[ins.core] = 16'h0000;
						s_d.stat[ins.core] = 16'h0000;
						s_d.diag[ins.core] = 8'h00;
					end
					MCDP_OP_SET_CTRL_BIT: s_d.ctrl[ins.core][ins.imm[3:0]] = ins.imm[`MCDP_BIT_VAL];
					MCDP_OP_SET_STAT_BIT: s_d.stat[ins.core][ins.imm[3:0]] = ins.imm[`MCDP_BIT_VAL];
					MCDP_OP_SET_FLAG:
						if (s_q.flag_dir[ins.imm[3:0]])
							s_d.flags[ins.imm[3:0]] = ins.imm[`MCDP_BIT_VAL];
					MCDP_OP_CNT_FROM_ALU:
					begin
						s_d.counter = s_q.gpr[ins.src[2:0]];
						s_d.drive = ins.dst;
					end
					MCDP_OP_CNT_FROM_MEM:
					begin
						s_d.counter = mem_rdata;
						s_d.drive = ins.dst;
					end
					MCDP_OP_JUMP_REL: s_d.pc = s_q.pc + {{5{ins.imm[4]}}, ins.imm[4:0]};
					MCDP_OP_JUMP_FAR: s_d.pc = s_q.jreg;
					MCDP_OP_LOAD_JREG: s_d.jreg = ins.imm[9:0];
					MCDP_OP_TEST_FLAG: s_d.tst = (s_q.flags[ins.imm[3:0]] == ins.imm[`MCDP_BIT_VAL]);
					MCDP_OP_SET_DIAG: s_d.diag[ins.core] = ins.imm[7:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_q <= `MCDP_RST_STATE;
		else
			s_q <= s_d;
	end

	// data memory, no reset
	always_ff @(posedge clk)
	begin
		if (mem_we)
			dmem[mem_addr] <= mem_wdata;
	end
	assign prdata       = s_q.prdata;
	assign pready       = s_q.pready;
	assign pslverr      = s_q.pslverr;
	assign flag_pin_out = s_q.flags;
	assign flag_pin_oe  = s_q.flag_dir;
	assign drive_out    = s_q.drive;
	// helper: cycles spent in the running shift and its requested length
	logic [4:0] sh_elapsed;
	logic [4:0] sh_len;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sh_elapsed <= `MCDP_SH_ZERO;
			sh_len <= `MCDP_SH_ZERO;
		end
		else if (exec && ins.op == MCDP_OP_SHIFT && !s_q.sh_busy)
		begin
			sh_elapsed <= `MCDP_SH_ZERO;
			sh_len <= s_d.sh_cnt;
		end
		else if (s_q.sh_busy)
			sh_elapsed <= sh_elapsed + `MCDP_SH_ONE;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	addr_index_a: assert property (exec && idxd |-> mem_addr == 6'(s_q.base + ins.imm[5:0]))
		else $error("indexed address not base plus offset");
	copy_nomem_a: assert property (exec && ins.op == MCDP_OP_REG_COPY |-> !mem_we)
		else $error("copy touched data memory");
	store_mem_a: assert property (mem_we |=> dmem[$past(mem_addr)] == $past(mem_wdata))
		else $error("store did not reach memory");
	shift_time_a: assert property ($fell(s_q.sh_busy) |-> sh_elapsed == sh_len)
		else $error("shift length differs from distance");
	done_clear_a: assert property (s_q.sh_busy |-> !s_q.op_done ##0 s_q.sh_cnt != `MCDP_SH_ZERO)
		else $error("done bit set during shift");
	byte_shift_a: assert property (exec && !s_q.sh_busy && ins.op == MCDP_OP_BYTE_SHIFT && ins.src[`MCDP_SH_LEFT]
		|=> s_q.gpr[$past(ins.dst[2:0])] == {$past(alu_in.a[7:0]), 8'h00})
		else $error("byte shift wrong");
	signed_msb_a: assert property (s_q.sh_busy && s_q.sh_sgn && !s_q.sh_pair
		|=> s_q.gpr[$past(s_q.sh_reg)][15] == $past(s_q.gpr[s_q.sh_reg][15]))
		else $error("signed shift changed msb");
	pair_link_a: assert property (s_q.sh_busy && s_q.sh_pair && s_q.sh_left && !s_q.sh_sgn
		|=> s_q.prod_hi[0] == $past(s_q.prod_lo[15]))
		else $error("pair shift broke the link");
	busy_refuse_a: assert property (exec && alu_op && s_q.sh_busy |=> s_q.err && $stable(s_q.pc))
		else $error("alu op accepted while shifting");
	mode_keep_a: assert property (!(exec && ins.op inside {MCDP_OP_SEL_MODE, MCDP_OP_SET_BASE,
		MCDP_OP_REG_COPY, MCDP_OP_LOAD}) |=> $stable(s_q.idx_mode) && $stable(s_q.base))
		else $error("base or mode changed unasked");

	long_shift_c: cover property (s_q.sh_busy [*8] ##1 !s_q.sh_busy);
	refused_c: cover property (exec && alu_op && s_q.sh_busy);
	indexed_load_c: cover property (exec && idxd && ins.op == MCDP_OP_LOAD);

endmodule
`default_nettype wire

// [dv/tb.sv]
// tb: self-checking bench for mcdp_core over apb, flag pins and counter outputs.
// assumes: mcdp_pkg compiled first; mcdp_regs.svh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "mcdp_regs.svh"
module tb
	import mcdp_pkg::*;
;
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, p, v;
	logic [15:0] flag_pin_in, flag_pin_out, flag_pin_oe, a, b;
	logic [3:0]  drive_out;
	logic [32:0] q_e[$], q_m[$];
	int          n_mismatch, tests_run, seed;
	mcdp_op_t    ops[13] = '{MCDP_OP_ADD, MCDP_OP_ADDI, MCDP_OP_SUB, MCDP_OP_SUBI, MCDP_OP_AND, MCDP_OP_OR,
		MCDP_OP_XOR, MCDP_OP_NOT, MCDP_OP_TO_SIGNED, MCDP_OP_TO_INT, MCDP_OP_SWAP, MCDP_OP_BYTE_SHIFT,
		MCDP_OP_BYTE_SHIFT};
	logic [3:0]  sm[6] = '{4'h0, 4'h9, 4'h5, 4'hD, 4'h3, 4'hB};

	mcdp_core u_mcdp_core (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flag_pin_in(flag_pin_in), .flag_pin_out(flag_pin_out), .flag_pin_oe(flag_pin_oe),
		.drive_out(drive_out));

	task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results;
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one apb transfer; request held until pready seen at a rising edge
	task automatic x(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			n_mismatch++;
	endtask

	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	// read: note {pslverr, prdata} expectation, then run the transfer
	task automatic rd(input logic [7:0] ad, input logic [32:0] e, input logic [32:0] m = '1);
		q_e.push_back(e & m);
		q_m.push_back(m);
		x(1'b0, ad, 32'h0);
	endtask

	task automatic ex(input mcdp_op_t op, input logic [1:0] c, input logic [3:0] d, input logic [3:0] s,
		input logic [15:0] i);
		x(1'b1, `MCDP_OFS_INSTR, {op, c, d, s, i});
	endtask

	// gpr load through both immediate halves and a copy
	task automatic sr(input logic [3:0] r, input logic [15:0] d);
		ex(MCDP_OP_IMM_HIGH_LOAD, 2'h0, 4'h0, 4'h0, {2{d[15:8]}});
		ex(MCDP_OP_IMM_LOW_LOAD, 2'h0, 4'h0, 4'h0, {2{d[7:0]}});
		ex(MCDP_OP_REG_COPY, 2'h0, r, `MCDP_IDX_IMM, 16'h0000);
	endtask

	task automatic rr(input logic [5:0] s, input logic [15:0] e);
		x(1'b1, `MCDP_OFS_RSEL, {26'h0, s});
		rd(`MCDP_OFS_RDATA, {17'h0, e});
	endtask

	function automatic logic [15:0] alu_ref(input mcdp_op_t op, input logic [15:0] a, input logic [15:0] b,
		input logic lft);
		case (op)
			MCDP_OP_ADD, MCDP_OP_ADDI: return a + b;
			MCDP_OP_SUB, MCDP_OP_SUBI: return a - b;
			MCDP_OP_AND: return a & b;
			MCDP_OP_OR: return a | b;
			MCDP_OP_XOR: return a ^ b;
			MCDP_OP_NOT: return ~a;
			MCDP_OP_TO_SIGNED: return a[15] ? 16'h0000 - {1'b0, a[14:0]} : a;
			MCDP_OP_TO_INT: return a[15] ? {1'b1, 15'(16'h0000 - a)} : a;
			MCDP_OP_SWAP: return {a[7:0], a[15:8]};
			default: return lft ? {a[7:0], 8'h00} : {8'h00, a[15:8]};
		endcase
	endfunction

	// md = {left, signed, pair, immediate}
	function automatic logic [31:0] sh_ref(input logic [3:0] md, input logic [31:0] v, input int n);
		repeat (n)
			if (md[1])
				v = md[3] ? v << 1 : v >> 1;
			else if (md[3])
				v = {16'h0, md[2] ? v[15] : v[14], v[13:0], 1'b0};
			else
				v = {16'h0, md[2] & v[15], v[15:1]};
		return v;
	endfunction

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// compare each read answer with the oldest note
	always @(posedge clk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			check("apb read", {pslverr, prdata} & q_m.pop_front(), q_e.pop_front());

	initial
	begin
		#40000;
		n_mismatch++;
		results;
	end

	initial
	begin
		seed = 32'h0EEE4FE6;
		{resetn, psel, penable, pwrite, paddr, pwdata} <= '0;
		flag_pin_in <= 16'h0000;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(8'h24, {1'b1, 32'h0});
		for (int k = 0; k < 13; k++)
		begin
			a = 16'($random(seed));
			b = 16'($random(seed));
			sr(4'h1, a);
			sr(4'h2, b);
			ex(ops[k], 2'h0, 4'h1, (k == 11) ? 4'h8 : 4'h2, 16'h0000);
			rr(6'h01, alu_ref(ops[k], a, b, k == 11));
		end
		for (int m = 0; m < 6; m++)
		begin
			a = 16'($random(seed));
			b = 16'($random(seed));
			p = a * b;
			if (!sm[m][0])
				sr(4'h3, 16'(m + 5));
			sr(4'h1, a);
			sr(4'h2, b);
			ex(m[0] ? MCDP_OP_MULI : MCDP_OP_MUL, 2'h0, 4'h1, 4'h2, 16'h0000);
			rr(6'h09, p[31:16]);
			rr(6'h0A, p[15:0]);
			ex(MCDP_OP_SHIFT, 2'h0, 4'h1, sm[m], sm[m][0] ? 16'(m + 5) : 16'h0003);
			rd(`MCDP_OFS_ARITH, 33'h10, 33'h11);
			if (m == 1)
				ex(MCDP_OP_ADD, 2'h0, 4'h1, 4'h2, 16'h0000);
			idle(14);
			rd(`MCDP_OFS_ARITH, (m == 1) ? 33'h5 : 33'h1, 33'h15);
			x(1'b1, `MCDP_OFS_ARITH, 32'h4);
			v = sh_ref(sm[m], sm[m][1] ? p : {16'h0, a}, m + 5);
			rr(sm[m][1] ? 6'h09 : 6'h01, sm[m][1] ? v[31:16] : v[15:0]);
			if (sm[m][1])
				rr(6'h0A, v[15:0]);
		end
		ex(MCDP_OP_SET_BASE, 2'h0, 4'h0, 4'h0, 16'h0005);
		ex(MCDP_OP_SEL_MODE, 2'h0, 4'h0, 4'h0, 16'h0001);
		ex(MCDP_OP_STORE, 2'h0, 4'h0, 4'h1, 16'h8002);
		ex(MCDP_OP_STORE, 2'h0, 4'h0, 4'h2, 16'h0002);
		ex(MCDP_OP_SEL_MODE, 2'h0, 4'h0, 4'h0, 16'h0000);
		ex(MCDP_OP_LOAD, 2'h0, 4'h3, 4'h0, 16'h8007);
		ex(MCDP_OP_REG_COPY, 2'h0, 4'h4, `MCDP_IDX_BASE, 16'h0000);
		ex(MCDP_OP_CNT_FROM_MEM, 2'h0, 4'h5, 4'h0, 16'h0002);
		rr(6'h03, a);
		rr(6'h04, 16'h0005);
		rr(6'h0C, b);
		check("drive_out", 33'(drive_out), 33'h5);
		ex(MCDP_OP_CNT_FROM_ALU, 2'h0, 4'hA, 4'h1, 16'h0000);
		rr(6'h0C, a);
		check("drive_out", 33'(drive_out), 33'hA);
		ex(MCDP_OP_SET_CTRL_BIT, 2'h2, 4'h0, 4'h0, 16'h0015);
		ex(MCDP_OP_SET_STAT_BIT, 2'h1, 4'h0, 4'h0, 16'h0013);
		ex(MCDP_OP_SET_DIAG, 2'h1, 4'h0, 4'h0, 16'h005A);
		x(1'b1, `MCDP_OFS_RSEL, 32'h20);
		rd(`MCDP_OFS_CTRL, 33'h20);
		rd(`MCDP_OFS_STAT, 33'h0);
		x(1'b1, `MCDP_OFS_RSEL, 32'h10);
		rd(`MCDP_OFS_STAT, 33'h8);
		rd(`MCDP_OFS_ARITH, 33'h5A00, 33'hFF00);
		ex(MCDP_OP_RST_REGS, 2'h1, 4'h0, 4'h0, 16'h0000);
		rd(`MCDP_OFS_STAT, 33'h0);
		rd(`MCDP_OFS_ARITH, 33'h0, 33'hFF00);
		x(1'b1, `MCDP_OFS_FDIR, 32'h00FF);
		flag_pin_in <= 16'($random(seed));
		ex(MCDP_OP_SET_FLAG, 2'h3, 4'h0, 4'h0, 16'h0012);
		ex(MCDP_OP_SET_FLAG, 2'h3, 4'h0, 4'h0, 16'h0019);
		ex(MCDP_OP_TEST_FLAG, 2'h0, 4'h0, 4'h0, 16'h0012);
		rd(`MCDP_OFS_ARITH, 33'h2, 33'h2);
		rd(`MCDP_OFS_FLAGS, {17'h0, flag_pin_in[15:8], 8'h04});
		check("flag_pin_oe", 33'(flag_pin_oe), 33'hFF);
		check("flag_pin_out", 33'(flag_pin_out[7:0]), 33'h4);
		// far jump then relative jump back sixteen
		ex(MCDP_OP_LOAD_JREG, 2'h0, 4'h0, 4'h0, 16'h0155);
		ex(MCDP_OP_JUMP_FAR, 2'h0, 4'h0, 4'h0, 16'h0000);
		ex(MCDP_OP_JUMP_REL, 2'h0, 4'h0, 4'h0, 16'h0010);
		rd(`MCDP_OFS_PC, 33'h01550145);
		idle(3);
		results;
	end
endmodule
`default_nettype wire
